// [design/pacc_pkg.sv]
// Shared constants, types and decode functions for the PWM and capture counter block
`default_nettype none
package pacc_pkg;
	localparam int PACC_NCH = 4;
	localparam int PACC_PWM_W = 8;
	localparam int PACC_PWM_PRE_W = 4;
	localparam int PACC_CNT_W = 32;
	localparam int PACC_CNT_PRE_W = 5;
	localparam int PACC_NPEND = 10;
	localparam int PACC_TICK_DIV_W = 2;
	localparam logic [PACC_TICK_DIV_W-1:0] PACC_TICK_DIV_LAST = 2'h3;
	localparam int PACC_PEND_PWM_OVF = 0;
	localparam int PACC_PEND_CNT_OVF = 1;
	localparam int PACC_PEND_CAP0 = 2;
	localparam int PACC_PEND_CMP0 = 6;
	localparam logic [PACC_PWM_W-1:0] PACC_PWM_CNT_RST = 8'h00;
	localparam logic [PACC_PWM_W-1:0] PACC_PWM_CNT_MAX = 8'hFF;
	localparam logic [PACC_PWM_PRE_W-1:0] PACC_PWM_PRE_RST = 4'h0;
	localparam logic [PACC_CNT_W-1:0] PACC_CNT_RST = 32'h0000_0000;
	localparam logic [PACC_CNT_W-1:0] PACC_CNT_MAX = 32'hFFFF_FFFF;
	localparam logic [PACC_CNT_PRE_W-1:0] PACC_CNT_PRE_RST = 5'h00;
	localparam logic [PACC_CNT_W-1:0] PACC_CAP_RST = 32'h0000_0000;
	localparam logic [PACC_CNT_W-1:0] PACC_CMP_RST = 32'h0000_0000;
	localparam logic [PACC_NPEND-1:0] PACC_PEND_RST = 10'h000;

	typedef enum logic [1:0] {
		PACC_EDGE_OFF = 2'b00,
		PACC_EDGE_RISE = 2'b01,
		PACC_EDGE_FALL = 2'b10,
		PACC_EDGE_BOTH = 2'b11
	} pacc_edge_t;

	// Qualify a sampled transition against the selected edge mode
	function automatic logic pacc_edge_hit(input pacc_edge_t mode, input logic prev, input logic cur);
		logic hit;
		hit = 1'b0;
		case (mode)
			PACC_EDGE_RISE: hit = ~prev & cur;
			PACC_EDGE_FALL: hit = prev & ~cur;
			PACC_EDGE_BOTH: hit = prev ^ cur;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction
endpackage
`default_nettype wire

// [design/pacc_pwm_if.sv]
// Carrier between the top level and the PWM generator
`default_nettype none
interface pacc_pwm_if;
	import pacc_pkg::*;
	logic run;
	logic [PACC_PWM_PRE_W-1:0] prescale;
	logic [PACC_NCH-1:0][PACC_PWM_W-1:0] duty;
	logic [PACC_NCH-1:0] level;
	logic ovf;
	modport ctl (output run, output prescale, output duty, input level, input ovf);
	modport gen (input run, input prescale, input duty, output level, output ovf);
endinterface
`default_nettype wire

// [design/pacc_pwm.sv]
// Four-channel PWM generator on one prescaled 8-bit counter
`default_nettype none
module pacc_pwm
	import pacc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	pacc_pwm_if.gen pwm
);
	logic [PACC_PWM_PRE_W-1:0] pre_ff;
	logic [PACC_PWM_PRE_W-1:0] nxt_pre;
	logic [PACC_PWM_W-1:0] cnt_ff;
	logic [PACC_PWM_W-1:0] nxt_cnt;
	logic [PACC_NCH-1:0] level_ff;
	logic [PACC_NCH-1:0] nxt_level;
	logic ovf_ff;
	wire tick = pwm.run && (pre_ff == pwm.prescale);
	wire wrap = tick && (cnt_ff == PACC_PWM_CNT_MAX);

	assign nxt_pre = (!pwm.run || tick) ? PACC_PWM_PRE_RST : pre_ff + 4'h1;
	assign nxt_cnt = !pwm.run ? PACC_PWM_CNT_RST : (tick ? cnt_ff + 8'h01 : cnt_ff);

	genvar g;
	generate
		for (g = 0; g < PACC_NCH; g++) begin : g_ch
			// Stopped outputs sit high so the first period starts high
			assign nxt_level[g] = !pwm.run ? 1'b1 :
				wrap ? 1'b1 :
				(cnt_ff == pwm.duty[g]) ? 1'b0 : level_ff[g];
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			pre_ff <= PACC_PWM_PRE_RST;
			cnt_ff <= PACC_PWM_CNT_RST;
			level_ff <= '1;
			ovf_ff <= 1'b0;
		end else if (ce_i) begin
			pre_ff <= nxt_pre;
			cnt_ff <= nxt_cnt;
			level_ff <= nxt_level;
			ovf_ff <= wrap;
		end
	end

	assign pwm.level = level_ff;
	assign pwm.ovf = ovf_ff && ce_i;

	property p_pwm_wrap_high;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && wrap |=> (level_ff == 4'hF) && (cnt_ff == PACC_PWM_CNT_RST) && ovf_ff;
	endproperty
	a_pwm_wrap_high: assert property (p_pwm_wrap_high) else $error("PWM outputs not high after wrap");

	property p_pwm_match_low;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && pwm.run && !wrap && (cnt_ff == pwm.duty[0]) |=> !level_ff[0];
	endproperty
	a_pwm_match_low: assert property (p_pwm_match_low) else $error("PWM output 0 not low on match");

	property p_pwm_stop_high;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && !pwm.run |=> (level_ff == 4'hF) && (cnt_ff == PACC_PWM_CNT_RST);
	endproperty
	a_pwm_stop_high: assert property (p_pwm_stop_high) else $error("PWM not high at start");

	property p_pwm_prescale;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && pwm.run && !tick |=> $stable(cnt_ff);
	endproperty
	a_pwm_prescale: assert property (p_pwm_prescale) else $error("PWM counter moved without tick");
endmodule
`default_nettype wire

// [design/pacc_top.sv]
// PWM generator and 32-bit capture/compare counter, top level
//
// Functional notes
// - One 8-bit PWM counter, 4-bit prescaler
// - Four 8-bit duties share one period
// - PWM outputs high when counter starts
// - Low on match, high on overflow
// - PWM counter overflow raises interrupt
// - PWM outputs share pins with captures
// - 32-bit counter on divide-by-4, 5-bit prescale
// - Four capture and four compare registers
// - Counter reloads start value on overflow
// - Capture event copies counter to register
// - Capture edge: rising, falling or both
// - Capture interrupts; read clears captured value
// - Compare match raises an interrupt
// - All events share one request line
// - Counter readable always, written only stopped
// - Compares read/write anytime, captures read-only
`default_nettype none
module pacc_top
	import pacc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [PACC_NCH-1:0] port_a_bit_i,
	output logic [PACC_NCH-1:0] port_a_bit_o,
	output logic [PACC_NCH-1:0] port_a_bit_oe_o,
	input wire logic [PACC_NCH-1:0] pwm_sel_i,
	input wire logic pwm_open_drain_i,
	input wire logic pwm_run_i,
	input wire logic [PACC_PWM_PRE_W-1:0] pwm_prescale_i,
	input wire logic [PACC_NCH-1:0][PACC_PWM_W-1:0] pwm_duty_i,
	input wire logic cnt_run_i,
	input wire logic [PACC_CNT_PRE_W-1:0] cnt_prescale_i,
	input wire logic [PACC_CNT_W-1:0] cnt_start_i,
	input wire logic cnt_wr_i,
	input wire logic [PACC_CNT_W-1:0] cnt_wr_data_i,
	output logic [PACC_CNT_W-1:0] cnt_value_o,
	input wire logic [PACC_NCH-1:0][1:0] cap_edge_i,
	input wire logic [PACC_NCH-1:0] cap_read_i,
	output logic [PACC_NCH-1:0][PACC_CNT_W-1:0] cap_value_o,
	input wire logic [PACC_NCH-1:0] cmp_wr_i,
	input wire logic [PACC_CNT_W-1:0] cmp_wr_data_i,
	output logic [PACC_NCH-1:0][PACC_CNT_W-1:0] cmp_value_o,
	input wire logic [PACC_NPEND-1:0] irq_en_i,
	input wire logic [PACC_NPEND-1:0] pend_clr_i,
	output logic [PACC_NPEND-1:0] pend_o,
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	// PWM generator and pin sharing

	pacc_pwm_if pwm_bus ();

	assign pwm_bus.run = pwm_run_i;
	assign pwm_bus.prescale = pwm_prescale_i;
	assign pwm_bus.duty = pwm_duty_i;

	pacc_pwm u_pwm (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.pwm(pwm_bus)
	);

	// Open drain only pulls low; the pin reads its own level back as capture input
	assign port_a_bit_o = pwm_bus.level;
	assign port_a_bit_oe_o = pwm_sel_i & (pwm_open_drain_i ? ~pwm_bus.level : 4'hF);

	////////////////////////////////////////////////////////////////////////////////
	// Capture pin synchronisers

	logic [PACC_NCH-1:0] pin_meta_ff;
	logic [PACC_NCH-1:0] pin_sync_ff;
	logic [PACC_NCH-1:0] pin_prev_ff;

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			pin_meta_ff <= 4'h0;
			pin_sync_ff <= 4'h0;
			pin_prev_ff <= 4'h0;
		end else if (ce_i) begin
			pin_meta_ff <= port_a_bit_i;
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Up-counter timebase

	logic [PACC_TICK_DIV_W-1:0] div_ff;
	logic [PACC_TICK_DIV_W-1:0] nxt_div;
	logic [PACC_CNT_PRE_W-1:0] pre_ff;
	logic [PACC_CNT_PRE_W-1:0] nxt_pre;
	logic [PACC_CNT_W-1:0] cnt_ff;
	logic [PACC_CNT_W-1:0] nxt_cnt;

	wire div_tick = cnt_run_i && (div_ff == PACC_TICK_DIV_LAST);
	wire cnt_tick = div_tick && (pre_ff == cnt_prescale_i);
	wire cnt_wrap = cnt_tick && (cnt_ff == PACC_CNT_MAX);
	// A write while running is dropped rather than corrupting a live count
	wire cnt_wr_ok = cnt_wr_i && !cnt_run_i;

	assign nxt_div = !cnt_run_i ? 2'h0 : div_ff + 2'h1;
	assign nxt_pre = (!cnt_run_i || cnt_tick) ? PACC_CNT_PRE_RST :
		(div_tick ? pre_ff + 5'h01 : pre_ff);
	assign nxt_cnt = cnt_wr_ok ? cnt_wr_data_i :
		cnt_wrap ? cnt_start_i :
		cnt_tick ? cnt_ff + 32'h0000_0001 : cnt_ff;

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			div_ff <= 2'h0;
			pre_ff <= PACC_CNT_PRE_RST;
			cnt_ff <= PACC_CNT_RST;
		end else if (ce_i) begin
			div_ff <= nxt_div;
			pre_ff <= nxt_pre;
			cnt_ff <= nxt_cnt;
		end
	end

	assign cnt_value_o = cnt_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Capture and compare channels

	logic [PACC_NCH-1:0][PACC_CNT_W-1:0] cap_ff;
	logic [PACC_NCH-1:0][PACC_CNT_W-1:0] nxt_cap;
	logic [PACC_NCH-1:0][PACC_CNT_W-1:0] cmp_ff;
	logic [PACC_NCH-1:0][PACC_CNT_W-1:0] nxt_cmp;
	logic [PACC_NCH-1:0] eq_ff;
	logic [PACC_NCH-1:0] cap_evt;
	logic [PACC_NCH-1:0] cmp_eq;
	logic [PACC_NCH-1:0] cmp_evt;

	genvar g;
	generate
		for (g = 0; g < PACC_NCH; g++) begin : g_ch
			assign cap_evt[g] = pacc_edge_hit(pacc_edge_t'(cap_edge_i[g]), pin_prev_ff[g], pin_sync_ff[g]);
			// A capture in the same cycle as a read keeps the new value
			assign nxt_cap[g] = cap_evt[g] ? cnt_ff :
				(cap_read_i[g] ? PACC_CAP_RST : cap_ff[g]);
			assign nxt_cmp[g] = cmp_wr_i[g] ? cmp_wr_data_i : cmp_ff[g];
			assign cmp_eq[g] = (cnt_ff == cmp_ff[g]);
			// Edge of equality, so a stopped counter does not refire
			assign cmp_evt[g] = cmp_eq[g] && !eq_ff[g];
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			cap_ff <= '0;
			cmp_ff <= '0;
			// Counter and compares reset equal, so equality must be regained before an event
			eq_ff <= 4'hF;
		end else if (ce_i) begin
			cap_ff <= nxt_cap;
			cmp_ff <= nxt_cmp;
			eq_ff <= cmp_eq;
		end
	end

	assign cap_value_o = cap_ff;
	assign cmp_value_o = cmp_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Pending flags and shared request

	logic [PACC_NPEND-1:0] pend_ff;
	logic [PACC_NPEND-1:0] nxt_pend;
	logic [PACC_NPEND-1:0] pend_set;

	assign pend_set[PACC_PEND_PWM_OVF] = pwm_bus.ovf;
	assign pend_set[PACC_PEND_CNT_OVF] = cnt_wrap;
	assign pend_set[PACC_PEND_CAP0 +: PACC_NCH] = cap_evt;
	assign pend_set[PACC_PEND_CMP0 +: PACC_NCH] = cmp_evt;
	// Set beats clear so no event is lost
	assign nxt_pend = (pend_ff & ~pend_clr_i) | pend_set;

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			pend_ff <= PACC_PEND_RST;
		end else if (ce_i) begin
			pend_ff <= nxt_pend;
		end
	end

	assign pend_o = pend_ff;
	assign irq_o = |(pend_ff & irq_en_i);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_cnt_reload;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && cnt_wrap |=> (cnt_ff == $past(cnt_start_i)) && pend_ff[PACC_PEND_CNT_OVF];
	endproperty
	a_cnt_reload: assert property (p_cnt_reload) else $error("Counter did not reload start value");

	property p_cnt_wr_stopped;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && cnt_wr_i && !cnt_run_i |=> cnt_ff == $past(cnt_wr_data_i);
	endproperty
	a_cnt_wr_stopped: assert property (p_cnt_wr_stopped) else $error("Counter write while stopped lost");

	property p_cnt_wr_running;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && cnt_run_i && !cnt_tick |=> $stable(cnt_ff);
	endproperty
	a_cnt_wr_running: assert property (p_cnt_wr_running) else $error("Counter changed between ticks");

	property p_cnt_rate;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		(ce_i && cnt_tick) ##1 (ce_i && cnt_run_i) [*3] |-> !cnt_tick;
	endproperty
	a_cnt_rate: assert property (p_cnt_rate) else $error("Counter tick off divide-by-4");

	property p_cap_copy;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && cap_evt[0] |=> (cap_ff[0] == $past(cnt_ff)) && pend_ff[PACC_PEND_CAP0];
	endproperty
	a_cap_copy: assert property (p_cap_copy) else $error("Capture 0 value or flag wrong");

	property p_cap_read_clear;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && cap_read_i[1] && !cap_evt[1] |=> cap_ff[1] == PACC_CAP_RST;
	endproperty
	a_cap_read_clear: assert property (p_cap_read_clear) else $error("Capture 1 not cleared by read");

	property p_cmp_match;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && $rose(cmp_eq[2]) |=> pend_ff[PACC_PEND_CMP0 + 2];
	endproperty
	a_cmp_match: assert property (p_cmp_match) else $error("Compare 2 match not flagged");

	property p_pend_sticky;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && pend_ff[PACC_PEND_PWM_OVF] && !pend_clr_i[PACC_PEND_PWM_OVF] |=> pend_ff[PACC_PEND_PWM_OVF];
	endproperty
	a_pend_sticky: assert property (p_pend_sticky) else $error("Pending flag dropped without clear");

	property p_irq_line;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		irq_o == ((pend_ff & irq_en_i) != 10'h000);
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("Request line disagrees with flags");

	property p_cap_keep;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && !cap_evt[2] && !cap_read_i[2] |=> $stable(cap_ff[2]);
	endproperty
	a_cap_keep: assert property (p_cap_keep) else $error("Capture 2 changed without event or read");

	property p_cmp_write;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && cmp_wr_i[3] |=> cmp_ff[3] == $past(cmp_wr_data_i);
	endproperty
	a_cmp_write: assert property (p_cmp_write) else $error("Compare 3 write lost");

	property p_cnt_hold_stopped;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && !cnt_run_i && !cnt_wr_i |=> $stable(cnt_ff);
	endproperty
	a_cnt_hold_stopped: assert property (p_cnt_hold_stopped) else $error("Stopped counter moved");

	property p_cap_rise_only;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && (cap_edge_i[0] == PACC_EDGE_RISE) && pin_prev_ff[0] && !pin_sync_ff[0] |-> !cap_evt[0];
	endproperty
	a_cap_rise_only: assert property (p_cap_rise_only) else $error("Capture 0 fired on falling edge");

	property p_cap_both;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && (cap_edge_i[2] == PACC_EDGE_BOTH) && (pin_prev_ff[2] != pin_sync_ff[2]) |=> pend_ff[PACC_PEND_CAP0 + 2];
	endproperty
	a_cap_both: assert property (p_cap_both) else $error("Capture 2 missed an edge");

	property p_cap_off;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && (cap_edge_i[3] == PACC_EDGE_OFF) && !cap_read_i[3] |=> $stable(cap_ff[3]);
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("Disabled capture 3 changed");

	property p_pwm_ovf_flag;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		pwm_bus.ovf |=> pend_ff[PACC_PEND_PWM_OVF];
	endproperty
	a_pwm_ovf_flag: assert property (p_pwm_ovf_flag) else $error("PWM overflow not flagged");

	property p_od_low_only;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		pwm_open_drain_i |-> (port_a_bit_oe_o & port_a_bit_o) == 4'h0;
	endproperty
	a_od_low_only: assert property (p_od_low_only) else $error("Open drain pin driven high");

	property p_cnt_flag_source;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		ce_i && !cnt_wrap && !pend_ff[PACC_PEND_CNT_OVF] |=> !pend_ff[PACC_PEND_CNT_OVF];
	endproperty
	a_cnt_flag_source: assert property (p_cnt_flag_source) else $error("Overflow flag set without wrap");
endmodule
`default_nettype wire

// [sim/pacc_pin_model.sv]
// Behavioural far side of the shared port pins: capture sources and pull-ups
`default_nettype none
module pacc_pin_model
	import pacc_pkg::*;
(
	input wire logic [PACC_NCH-1:0] src_level_i,
	input wire logic [PACC_NCH-1:0] src_drive_i,
	input wire logic [PACC_NCH-1:0] dev_out_i,
	input wire logic [PACC_NCH-1:0] dev_oe_i,
	output logic [PACC_NCH-1:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// A pin nobody drives floats up to the external pull-up, never to a stale level
	always_comb begin
		for (int i = 0; i < PACC_NCH; i++) begin
			pin_o[i] = dev_oe_i[i] ? dev_out_i[i] : (src_drive_i[i] ? src_level_i[i] : 1'b1);
		end
	end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the PWM and capture counter top level
`default_nettype none
module tb_top
	import pacc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic pwm_open_drain_i = 1'b0;
	logic pwm_run_i = 1'b0;
	logic cnt_run_i = 1'b0;
	logic cnt_wr_i = 1'b0;
	logic [3:0] pwm_sel_i = 4'h0;
	logic [3:0] cap_read_i = 4'h0;
	logic [3:0] cmp_wr_i = 4'h0;
	logic [3:0] pwm_prescale_i = 4'h0;
	logic [4:0] cnt_prescale_i = 5'h00;
	logic [31:0] cnt_start_i = 32'h0000_0001;
	logic [31:0] cnt_wr_data_i = 32'h0000_0000;
	logic [31:0] cmp_wr_data_i = 32'h0000_0000;
	logic [3:0][7:0] pwm_duty_i = '0;
	logic [3:0][1:0] cap_edge_i = '0;
	logic [9:0] irq_en_i = 10'h000;
	logic [9:0] pend_clr_i = 10'h000;
	logic [3:0] src_level = 4'h0;
	logic [3:0] src_drive = 4'hF;
	logic [3:0] port_a_bit_i;
	logic [3:0] port_a_bit_o;
	logic [3:0] port_a_bit_oe_o;
	logic [31:0] cnt_value_o;
	logic [3:0][31:0] cap_value_o;
	logic [3:0][31:0] cmp_value_o;
	logic [9:0] pend_o;
	logic irq_o;
	int n_errors = 0;
	int comparisons = 0;
	int sel_q[$];
	logic [31:0] exp_q[$];
	int hc[5];
	event look;

	always #2 clk_sys_i = ~clk_sys_i;

	pacc_top i_pacc_top (.clk_sys_i, .nrst_i, .ce_i, .port_a_bit_i, .port_a_bit_o, .port_a_bit_oe_o,
		.pwm_sel_i, .pwm_open_drain_i, .pwm_run_i, .pwm_prescale_i, .pwm_duty_i, .cnt_run_i, .cnt_prescale_i,
		.cnt_start_i, .cnt_wr_i, .cnt_wr_data_i, .cnt_value_o, .cap_edge_i, .cap_read_i, .cap_value_o,
		.cmp_wr_i, .cmp_wr_data_i, .cmp_value_o, .irq_en_i, .pend_clr_i, .pend_o, .irq_o);
	pacc_pin_model i_pacc_pin_model (.src_level_i(src_level), .src_drive_i(src_drive),
		.dev_out_i(port_a_bit_o), .dev_oe_i(port_a_bit_oe_o), .pin_o(port_a_bit_i));

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] obs(input int s);
		if (s < 4) return cap_value_o[s];
		if (s < 8) return cmp_value_o[s-4];
		case (s)
			8: return cnt_value_o;
			9: return {22'h0, pend_o};
			10: return {24'h0, port_a_bit_oe_o, port_a_bit_o};
			11: return {31'h0, irq_o};
			default: return 32'(hc[s-12]);
		endcase
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Notes land in one time step; the watcher drains them before the driver moves on
	always @(look) begin
		while (exp_q.size() > 0) check(obs(sel_q.pop_front()), exp_q.pop_front());
	end

	task automatic note(input int s, input logic [31:0] e);
		sel_q.push_back(s);
		exp_q.push_back(e);
		->look;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic wr_cnt(input logic [31:0] v);
		cnt_wr_data_i = v;
		cnt_wr_i = 1'b1;
		cyc(1);
		cnt_wr_i = 1'b0;
	endtask

	task automatic clr_pend();
		pend_clr_i = 10'h3FF;
		cyc(1);
		pend_clr_i = 10'h000;
	endtask

	// Clears the overflow flag, then counts cycles until it is set again
	task automatic wait_wrap(output int n);
		pend_clr_i = 10'h001;
		cyc(1);
		pend_clr_i = 10'h000;
		n = 1;
		while (pend_o[0] !== 1'b1 && n < 5000) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		int n;
		logic [31:0] w;
		logic [1:0] md[4];
		void'($urandom(65));
		md = '{PACC_EDGE_RISE, PACC_EDGE_FALL, PACC_EDGE_BOTH, PACC_EDGE_OFF};
		cyc(3);
		nrst_i = 1'b1;
		cyc(1);
		note(9, 32'h0);
		note(10, 32'h0F);
		note(11, 32'h0);
		w = $urandom();
		wr_cnt(w);
		note(8, w);
		cnt_run_i = 1'b1;
		wr_cnt(~w);
		cnt_run_i = 1'b0;
		note(8, w);
		cnt_start_i = $urandom() | 32'h1;
		cnt_prescale_i = 5'h01;
		irq_en_i = 10'h002;
		wr_cnt(32'hFFFF_FFFE);
		clr_pend();
		cnt_run_i = 1'b1;
		cyc(12);
		note(8, 32'hFFFF_FFFF);
		cyc(8);
		note(8, cnt_start_i);
		note(9, 32'h2);
		note(11, 32'h1);
		cnt_run_i = 1'b0;
		clr_pend();
		note(11, 32'h0);
		irq_en_i = 10'h3FC;
		for (int i = 0; i < 4; i++) begin
			cap_edge_i[i] = md[i];
			w = $urandom() | 32'h1;
			wr_cnt(w);
			src_level[i] = 1'b1;
			cyc(8);
			note(i, md[i][0] ? w : 32'h0);
			note(9, md[i][0] ? 32'h4 << i : 32'h0);
			note(11, {31'h0, md[i][0]});
			cap_read_i[i] = 1'b1;
			clr_pend();
			cap_read_i[i] = 1'b0;
			note(i, 32'h0);
			wr_cnt(w + 32'h2);
			src_level[i] = 1'b0;
			cyc(8);
			note(i, md[i][1] ? w + 32'h2 : 32'h0);
			cap_read_i[i] = 1'b1;
			clr_pend();
			cap_read_i[i] = 1'b0;
		end
		irq_en_i = 10'h000;
		for (int j = 0; j < 4; j++) begin
			w = $urandom() & 32'hFFFF_FFFE;
			cmp_wr_data_i = w;
			cmp_wr_i[j] = 1'b1;
			cyc(1);
			cmp_wr_i[j] = 1'b0;
			note(4 + j, w);
			clr_pend();
			wr_cnt(w);
			cyc(1);
			note(9, 32'h40 << j);
		end
		ce_i = 1'b0;
		wr_cnt(~w);
		ce_i = 1'b1;
		note(8, w);
		// Edge detection off so the PWM pin activity raises no capture flags
		cap_edge_i = '0;
		clr_pend();
		src_drive = 4'h0;
		pwm_sel_i = 4'hF;
		pwm_prescale_i = 4'($urandom_range(3, 1));
		pwm_duty_i = {8'hFF, 8'($urandom()), 8'($urandom()), 8'h00};
		pwm_run_i = 1'b1;
		wait_wrap(n);
		wait_wrap(hc[4]);
		note(16, 32'h100 * ({28'h0, pwm_prescale_i} + 32'h1));
		pwm_run_i = 1'b0;
		pwm_prescale_i = 4'h0;
		cyc(2);
		note(10, 32'hFF);
		cyc(1);
		pwm_open_drain_i = 1'b1;
		note(10, 32'h0F);
		cyc(1);
		pwm_open_drain_i = 1'b0;
		pwm_run_i = 1'b1;
		wait_wrap(n);
		note(10, {24'h0, 4'hF, (pwm_duty_i[3] != 8'h00), (pwm_duty_i[2] != 8'h00),
			(pwm_duty_i[1] != 8'h00), (pwm_duty_i[0] != 8'h00)});
		note(9, 32'h1);
		hc = '{default: 0};
		// Sampling covers one whole period, starting one cycle after the wrap
		repeat (256) begin
			for (int c = 0; c < 4; c++) hc[c] += port_a_bit_o[c];
			cyc(1);
		end
		for (int c = 0; c < 4; c++) note(12 + c, {24'h0, pwm_duty_i[c]} + 32'h1);
		cyc(2);
		finish_test();
	end

	initial begin
		#100us;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
